// File: hdl/sbsa_pkg.sv
package sbsa_pkg;

    // ----------------------------------------------------------------
    // Widths and address layout (word addresses on both sides)
    // ----------------------------------------------------------------
    localparam int ADR_W = 13;
    localparam int DAT_W = 32;
    localparam int SEL_W = 2;
    localparam int HALF_W = 16;
    localparam int RES_W = 4;
    localparam int MIDX_W = 11;
    localparam int NUM_BUF = 8;
    localparam int NUM_SEM = 7;
    localparam int NUM_RES = 15;
    localparam int BUF_DEPTH = 256;
    localparam int REGION_MSB = 12;
    localparam int IDX_MSB = 10;
    localparam int SEM_BIT = 0;

    localparam logic [1:0] REGION_MEM = 2'h0;
    localparam logic [1:0] REGION_SEM = 2'h1;
    localparam logic [1:0] REGION_LOCAL = 2'h2;
    localparam logic [2:0] IDX_NO_SEM = 3'h7;
    localparam logic [RES_W-1:0] SEM_RES_BASE = 4'h8;

    // ----------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [ADR_W-1:0] BUFFER_A_OWNERSHIP_FLAG_OFS = 13'h0800;
    localparam logic [ADR_W-1:0] BUFFER_B_OWNERSHIP_FLAG_OFS = 13'h0900;
    localparam logic [ADR_W-1:0] BUFFER_C_OWNERSHIP_FLAG_OFS = 13'h0a00;
    localparam logic [ADR_W-1:0] BUFFER_D_OWNERSHIP_FLAG_OFS = 13'h0b00;
    localparam logic [ADR_W-1:0] BUFFER_E_OWNERSHIP_FLAG_OFS = 13'h0c00;
    localparam logic [ADR_W-1:0] BUFFER_F_OWNERSHIP_FLAG_OFS = 13'h0d00;
    localparam logic [ADR_W-1:0] BUFFER_G_OWNERSHIP_FLAG_OFS = 13'h0e00;
    localparam logic [ADR_W-1:0] LOCAL_SCRATCH_OFS = 13'h1000;
    localparam logic SEM_FREE = 1'b0;
    localparam logic SEM_TAKEN = 1'b1;
    localparam logic [DAT_W-1:0] LOCAL_RST = 32'h0000_0000;

    typedef enum logic [1:0] {V_IDLE, V_RD, V_DONE} vme_state_t;

    function automatic logic [RES_W-1:0] res_of(input logic [ADR_W-1:0] adr);
        logic [RES_W-1:0] idx;
        idx = {1'b0, adr[IDX_MSB -: 3]};
        res_of = (adr[REGION_MSB -: 2] == REGION_SEM) ? RES_W'(SEM_RES_BASE + idx) : idx;
    endfunction

    function automatic logic is_shared(input logic [ADR_W-1:0] adr);
        is_shared = (adr[REGION_MSB -: 2] == REGION_MEM) ||
                    ((adr[REGION_MSB -: 2] == REGION_SEM) && (adr[IDX_MSB -: 3] != IDX_NO_SEM));
    endfunction

    function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_d,
                                               input logic [DAT_W-1:0] new_d,
                                               input logic [SEL_W-1:0] sel);
        merge = old_d;
        for (int h = 0; h < SEL_W; h++) begin
            if (sel[h]) merge[h*HALF_W +: HALF_W] = new_d[h*HALF_W +: HALF_W];
        end
    endfunction

endpackage

// File: hdl/shared_buffer_semaphore_arbiter.sv
// Functional notes
// (RULE_01) Seven flags, bit 0, read 0 grants
// (RULE_02) Reading a free flag returns 0, takes it
// (RULE_03) Write 0 releases, write 1 ignored
// (RULE_04) Either side may release any flag
// (RULE_05) Flags never gate buffer arbitration
// (RULE_06) Eight 32-bit buffers, 16-bit write lanes
// (RULE_07) One independent arbiter per buffer
// (RULE_08) Flags use the same arbiter as buffers
// (RULE_09) Free resource granted at once, one owner
// (RULE_10) Same-cycle tie goes to VMEbus side
// (RULE_11) PCI keeps grant until cycle ends
// (RULE_12) PCI uses single transfers on flags
// (RULE_13) VMEbus write posted, acknowledged, then delivered
// (RULE_14) No new VMEbus cycle while latch full
// (RULE_15) VMEbus read waits grant, latches, acknowledges
// (RULE_16) Resource freed once read data latched
// (RULE_17) System reset clears block; PCI reset not
// (RULE_18) Local registers need no arbitration
// (RULE_19) Flags reset to free
`timescale 1ns/1ps
`default_nettype none

module shared_buffer_semaphore_arbiter (
    input wire logic clk_i, // Bridge clock, 50 MHz
    input wire logic rst_i, // System reset, active high
    input wire logic vme_cyc_i, // VMEbus slave cycle active
    input wire logic vme_we_i, // VMEbus write
    input wire logic [sbsa_pkg::ADR_W-1:0] vme_adr_i, // VMEbus word address
    input wire logic [sbsa_pkg::DAT_W-1:0] vme_dat_i, // VMEbus write data
    input wire logic [sbsa_pkg::SEL_W-1:0] vme_sel_i, // VMEbus 16-bit lane selects
    output logic vme_dtack_o, // VMEbus data acknowledge
    output logic [sbsa_pkg::DAT_W-1:0] vme_dat_o, // VMEbus posted read latch
    input wire logic pci_cyc_i, // PCI target cycle or burst active
    input wire logic pci_stb_i, // PCI data phase request
    input wire logic pci_we_i, // PCI write
    input wire logic [sbsa_pkg::ADR_W-1:0] pci_adr_i, // PCI word address
    input wire logic [sbsa_pkg::DAT_W-1:0] pci_dat_i, // PCI write data
    input wire logic [sbsa_pkg::SEL_W-1:0] pci_sel_i, // PCI 16-bit lane selects
    output logic pci_ack_o, // PCI data phase done
    output logic [sbsa_pkg::DAT_W-1:0] pci_dat_o // PCI read data
);
    import sbsa_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [DAT_W-1:0] mem_ff [0:NUM_BUF*BUF_DEPTH-1]; // [RULE_06]
    // One flag bit per buffer A..G, set means taken
    logic [NUM_SEM-1:0] sem_ff;

    // Grants; 0..7 are buffers, 8..14 are flags
    logic [NUM_RES-1:0] vme_gnt_ff;
    logic [NUM_RES-1:0] pci_gnt_ff;
    logic [NUM_RES-1:0] vme_req;
    logic [NUM_RES-1:0] pci_req;

    // Flag events per side
    logic [NUM_SEM-1:0] v_sem_hit;
    logic [NUM_SEM-1:0] p_sem_hit;
    logic [NUM_SEM-1:0] v_sem_take;
    logic [NUM_SEM-1:0] p_sem_take;
    logic [NUM_SEM-1:0] v_sem_clr;
    logic [NUM_SEM-1:0] p_sem_clr;
    logic [NUM_SEM-1:0] sem_take;
    logic [NUM_SEM-1:0] sem_clr;

    // VMEbus slave state and posted latches
    vme_state_t state_ff;
    logic dtack_ff;
    logic [DAT_W-1:0] vme_dat_ff;
    logic pw_full_ff;
    logic [ADR_W-1:0] pw_adr_ff;
    logic [DAT_W-1:0] pw_dat_ff;
    logic [SEL_W-1:0] pw_sel_ff;
    logic [DAT_W-1:0] vme_local_ff;

    // PCI target state
    logic pci_ack_ff;
    logic [DAT_W-1:0] pci_dat_ff;
    logic [DAT_W-1:0] pci_local_ff;

    // ----------------------------------------------------------------
    // VMEbus side decode
    // ----------------------------------------------------------------
    // Index 7 has no flag and reads as zero
    wire [NUM_SEM:0] sem_vec = {1'b0, sem_ff};

    // New cycles are refused while posted write data is undelivered
    wire v_idle = (state_ff == V_IDLE);
    wire v_start = v_idle && vme_cyc_i && !pw_full_ff; // [RULE_14]
    wire v_shared = is_shared(vme_adr_i);
    wire v_local = (vme_adr_i[REGION_MSB -: 2] == REGION_LOCAL);
    wire v_new_wr = v_start && vme_we_i && v_shared;
    wire v_new_rd = v_start && !vme_we_i && v_shared;
    wire v_new_plain = v_start && !v_shared;
    wire v_plain_wr = v_new_plain && vme_we_i && v_local;
    wire [DAT_W-1:0] v_plain_rdata = v_local ? vme_local_ff : '0;

    // ----------------------------------------------------------------
    // VMEbus pending shared access
    // ----------------------------------------------------------------
    // The posted write goes first; a read only starts on an empty latch
    wire v_req_act = pw_full_ff || (state_ff == V_RD);
    wire [ADR_W-1:0] v_acc_adr = pw_full_ff ? pw_adr_ff : vme_adr_i;
    wire [RES_W-1:0] v_req_res = res_of(v_acc_adr);
    wire v_go = v_req_act && vme_gnt_ff[v_req_res];
    wire v_pw_go = v_go && pw_full_ff; // [RULE_13]
    wire v_rd_go = v_go && !pw_full_ff; // [RULE_15]

    // ----------------------------------------------------------------
    // VMEbus access target
    // ----------------------------------------------------------------
    wire v_is_sem = (v_acc_adr[REGION_MSB -: 2] == REGION_SEM);
    wire [2:0] v_idx = v_acc_adr[IDX_MSB -: 3];
    wire [MIDX_W-1:0] v_midx = v_acc_adr[MIDX_W-1:0];
    wire [DAT_W-1:0] v_flag_rdata = {{(DAT_W-1){1'b0}}, sem_vec[v_idx]}; // [RULE_01]
    wire [DAT_W-1:0] v_rdata = v_is_sem ? v_flag_rdata : mem_ff[v_midx];
    wire v_mem_wr = v_pw_go && !v_is_sem;
    wire v_flag_wr = v_pw_go && v_is_sem;
    // Only lane 0 carries the flag bit
    wire v_flag_free = pw_sel_ff[0] && !pw_dat_ff[SEM_BIT]; // [RULE_03]

    // ----------------------------------------------------------------
    // PCI side decode
    // ----------------------------------------------------------------
    // A data phase is served every other cycle since ack is registered
    wire p_act = pci_cyc_i && pci_stb_i && !pci_ack_ff;
    wire p_shared = is_shared(pci_adr_i);
    wire [1:0] p_region = pci_adr_i[REGION_MSB -: 2];
    wire [RES_W-1:0] p_res = res_of(pci_adr_i);
    wire p_go = p_act && (p_shared ? pci_gnt_ff[p_res] : 1'b1); // [RULE_18]
    wire p_rd_go = p_go && !pci_we_i;
    wire p_wr_go = p_go && pci_we_i;

    // ----------------------------------------------------------------
    // PCI access target
    // ----------------------------------------------------------------
    wire p_is_sem = (p_region == REGION_SEM);
    wire p_is_local = (p_region == REGION_LOCAL);
    wire [2:0] p_idx = pci_adr_i[IDX_MSB -: 3];
    wire [MIDX_W-1:0] p_midx = pci_adr_i[MIDX_W-1:0];
    wire p_mem_wr = p_wr_go && (p_region == REGION_MEM);
    wire p_loc_wr = p_wr_go && p_is_local;
    wire p_flag_wr = p_wr_go && p_is_sem;
    // Either side may release, whoever took the flag
    wire p_flag_free = pci_sel_i[0] && !pci_dat_i[SEM_BIT]; // [RULE_03]

    // ----------------------------------------------------------------
    // PCI read data; unmapped space reads as zero
    // ----------------------------------------------------------------
    wire [DAT_W-1:0] p_flag_rdata = {{(DAT_W-1){1'b0}}, sem_vec[p_idx]}; // [RULE_01]
    wire [DAT_W-1:0] p_plain_rdata = p_is_local ? pci_local_ff : '0;
    wire [DAT_W-1:0] p_shared_rdata = p_is_sem ? p_flag_rdata : mem_ff[p_midx];
    wire [DAT_W-1:0] p_rdata = p_shared ? p_shared_rdata : p_plain_rdata;

    // ----------------------------------------------------------------
    // Per-resource arbiters: buffers 0..7, flags 8..14
    // ----------------------------------------------------------------
    // Requests look only at addresses, never at flag values [RULE_05]
    // A VMEbus grant lasts one access; a PCI grant lasts the whole cycle
    for (genvar r = 0; r < NUM_RES; r++) begin : g_arb
        assign vme_req[r] = v_req_act && (v_req_res == RES_W'(r));
        assign pci_req[r] = p_act && p_shared && (p_res == RES_W'(r));

        wire arb_free = !vme_gnt_ff[r] && !pci_gnt_ff[r]; // [RULE_09]
        wire vme_done = vme_gnt_ff[r] && v_go; // [RULE_16]
        wire pci_done = pci_gnt_ff[r] && !pci_cyc_i; // [RULE_11]

        always_ff @(posedge clk_i or posedge rst_i) begin // [RULE_07] [RULE_08]
            if (rst_i) begin
                vme_gnt_ff[r] <= 1'b0;
                pci_gnt_ff[r] <= 1'b0;
            end else if (arb_free) begin
                if (vme_req[r]) begin // [RULE_10]
                    vme_gnt_ff[r] <= 1'b1; // [RULE_09]
                end else if (pci_req[r]) begin
                    pci_gnt_ff[r] <= 1'b1;
                end
            end else begin
                if (vme_done) begin // [RULE_16]
                    vme_gnt_ff[r] <= 1'b0;
                end
                if (pci_done) begin // [RULE_11]
                    pci_gnt_ff[r] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Ownership flags
    // ----------------------------------------------------------------
    // Arbiter guarantees one side at a time, so take and release never meet;
    // should they ever coincide, the take wins
    for (genvar s = 0; s < NUM_SEM; s++) begin : g_sem
        assign v_sem_hit[s] = v_is_sem && (v_idx == 3'(s));
        assign p_sem_hit[s] = p_is_sem && (p_idx == 3'(s));
        assign v_sem_take[s] = v_rd_go && v_sem_hit[s]; // [RULE_02]
        assign p_sem_take[s] = p_rd_go && p_sem_hit[s]; // [RULE_02]

        assign v_sem_clr[s] = v_flag_wr && v_sem_hit[s] && v_flag_free; // [RULE_04]
        assign p_sem_clr[s] = p_flag_wr && p_sem_hit[s] && p_flag_free; // [RULE_04]
        assign sem_take[s] = v_sem_take[s] || p_sem_take[s];
        assign sem_clr[s] = v_sem_clr[s] || p_sem_clr[s];

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                sem_ff[s] <= SEM_FREE; // [RULE_19]
            end else if (sem_take[s]) begin
                sem_ff[s] <= SEM_TAKEN;
            end else if (sem_clr[s]) begin
                sem_ff[s] <= SEM_FREE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Shared buffers
    // ----------------------------------------------------------------
    // No reset on the array; two write ports never hit one buffer together
    // Buffers A..H sit back to back, 256 words each
    always_ff @(posedge clk_i) begin
        if (v_mem_wr) begin
            mem_ff[v_midx] <= merge(mem_ff[v_midx], pw_dat_ff, pw_sel_ff); // [RULE_06]
        end
        if (p_mem_wr) begin
            mem_ff[p_midx] <= merge(mem_ff[p_midx], pci_dat_i, pci_sel_i);
        end
    end

    // ----------------------------------------------------------------
    // VMEbus slave with posted latches
    // ----------------------------------------------------------------
    // Reset is the system reset only; the PCI core reset is not wired here [RULE_17]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= V_IDLE;
            dtack_ff <= 1'b0;
            vme_dat_ff <= '0;
        end else begin
            case (state_ff)
                V_IDLE: begin
                    // Write is acknowledged at once and delivered later
                    if (v_new_wr) begin // [RULE_13]
                        dtack_ff <= 1'b1;
                        state_ff <= V_DONE;
                    end else if (v_new_rd) begin
                        state_ff <= V_RD;
                    end else if (v_new_plain) begin // [RULE_18]
                        vme_dat_ff <= v_plain_rdata;
                        dtack_ff <= 1'b1;
                        state_ff <= V_DONE;
                    end
                end
                // Grant is handed back as soon as data sits in the latch
                V_RD: begin
                    if (v_rd_go) begin // [RULE_15]
                        vme_dat_ff <= v_rdata;
                        dtack_ff <= 1'b1;
                        state_ff <= V_DONE;
                    end
                end
                // Hold acknowledge and data until the master ends the cycle
                V_DONE: begin
                    if (!vme_cyc_i) begin
                        dtack_ff <= 1'b0;
                        state_ff <= V_IDLE;
                    end
                end
                default: begin
                    state_ff <= V_IDLE;
                end
            endcase
        end
    end

    // Posted write latch; filled on acknowledge, emptied on delivery
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pw_full_ff <= 1'b0;
            pw_adr_ff <= '0;
            pw_dat_ff <= '0;
            pw_sel_ff <= '0;
        end else if (v_new_wr) begin // [RULE_13]
            pw_full_ff <= 1'b1;
            pw_adr_ff <= vme_adr_i;
            pw_dat_ff <= vme_dat_i;
            pw_sel_ff <= vme_sel_i;
        end else if (v_pw_go) begin
            pw_full_ff <= 1'b0;
        end
    end

    // VMEbus side scratch register, never arbitrated
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vme_local_ff <= LOCAL_RST;
        end else if (v_plain_wr) begin // [RULE_18]
            vme_local_ff <= merge(vme_local_ff, vme_dat_i, vme_sel_i);
        end
    end

    // ----------------------------------------------------------------
    // PCI target data phases
    // ----------------------------------------------------------------
    // Registered acknowledge costs a cycle per phase but keeps the output a flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pci_ack_ff <= 1'b0;
        end else begin
            pci_ack_ff <= p_go;
        end
    end

    // Read data stays until the next read phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pci_dat_ff <= '0;
        end else if (p_rd_go) begin
            pci_dat_ff <= p_rdata;
        end
    end

    // PCI side scratch register, never arbitrated
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pci_local_ff <= LOCAL_RST;
        end else if (p_loc_wr) begin // [RULE_18]
            pci_local_ff <= merge(pci_local_ff, pci_dat_i, pci_sel_i);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign vme_dtack_o = dtack_ff;
    assign vme_dat_o = vme_dat_ff;
    assign pci_ack_o = pci_ack_ff;
    assign pci_dat_o = pci_dat_ff;

endmodule // shared_buffer_semaphore_arbiter
`default_nettype wire

// File: test/pci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
    input wire logic clk_i, // Clock
    input wire logic ack_i, // Phase done
    input wire logic [31:0] rd_i, // Read data
    output logic cyc_o, // Cycle
    output logic stb_o, // Phase request
    output logic we_o, // Write
    output logic [12:0] adr_o, // Address
    output logic [31:0] wd_o, // Write data
    output logic [1:0] sel_o // Lanes
);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, wd_o, sel_o} = '0;
    end
    // Keep holds the grant like a stalled burst
    task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [1:0] s,
        input logic keep, output logic [31:0] q, output int c);
        c = 0;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, wd_o, sel_o} <= {2'h3, w, a, d, s};
        do begin
            @(posedge clk_i);
            c++;
        end while (ack_i !== 1'b1 && c < 200);
        q = rd_i;
        stb_o <= 1'b0; // One phase per cycle
        cyc_o <= keep;
        adr_o <= ~a;
        wd_o <= ~d;
    endtask
    task automatic drop();
        @(posedge clk_i);
        cyc_o <= 1'b0;
    endtask
endmodule // pci_host_model
`default_nettype wire

// File: test/sbsa_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbsa_chk (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic vme_cyc_i, // VME cycle
    input wire logic vme_we_i, // VME write
    input wire logic [12:0] vme_adr_i, // VME address
    input wire logic vme_dtack_o, // VME acknowledge
    input wire logic [31:0] vme_dat_o, // VME read latch
    input wire logic pci_cyc_i, // PCI cycle
    input wire logic pci_stb_i, // PCI phase
    input wire logic pci_we_i, // PCI write
    input wire logic [12:0] pci_adr_i, // PCI address
    input wire logic pci_ack_o, // PCI acknowledge
    input wire logic [31:0] pci_dat_o // PCI read data
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // --------------------------------
    // VME side
    // --------------------------------
    property p_dtack_stand; vme_dtack_o && vme_cyc_i |=> vme_dtack_o; endproperty
    a_dtack_stand: assert property (p_dtack_stand) else $error("dtack dropped early");
    property p_dtack_drop; !vme_cyc_i |=> !vme_dtack_o; endproperty
    a_dtack_drop: assert property (p_dtack_drop) else $error("dtack without cycle");
    property p_vdat_hold; vme_dtack_o && $past(vme_dtack_o) |-> $stable(vme_dat_o); endproperty
    a_vdat_hold: assert property (p_vdat_hold) else $error("read latch moved");
    property p_vrd_wait; $rose(vme_cyc_i) && !vme_we_i && vme_adr_i[12:11] == 2'h0 |-> !vme_dtack_o [*3]; endproperty
    a_vrd_wait: assert property (p_vrd_wait) else $error("read acked before grant");
    property p_vflag;
        vme_dtack_o && vme_cyc_i && !vme_we_i && vme_adr_i[12:11] == 2'h1 |-> vme_dat_o[31:1] == 31'h0;
    endproperty
    a_vflag: assert property (p_vflag) else $error("flag upper bits set");
    // --------------------------------
    // PCI side, then covers for both sides
    // --------------------------------
    property p_ack_pulse; pci_ack_o |=> !pci_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; pci_ack_o |-> $past(pci_cyc_i && pci_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_local; pci_cyc_i && pci_stb_i && !pci_ack_o && pci_adr_i[12:11] == 2'h2 |=> pci_ack_o; endproperty
    a_local: assert property (p_local) else $error("local access delayed");
    property p_prd_wait; $rose(pci_cyc_i) && pci_adr_i[12:11] == 2'h0 |-> !pci_ack_o [*2]; endproperty
    a_prd_wait: assert property (p_prd_wait) else $error("buffer acked before grant");
    c_vrd: cover property (vme_dtack_o && !vme_we_i);
    c_stall: cover property (vme_cyc_i && !vme_dtack_o [*8]);
    c_hold: cover property (pci_cyc_i && !pci_stb_i [*4]);
endmodule // sbsa_chk
bind shared_buffer_semaphore_arbiter sbsa_chk chk_u (.clk_i, .rst_i, .vme_cyc_i, .vme_we_i, .vme_adr_i,
    .vme_dtack_o, .vme_dat_o, .pci_cyc_i, .pci_stb_i, .pci_we_i, .pci_adr_i, .pci_ack_o, .pci_dat_o);
`default_nettype wire

// File: test/shared_buffer_semaphore_arbiter_test.sv
`timescale 1ns/1ps
`default_nettype none
module shared_buffer_semaphore_arbiter_test;
    import sbsa_pkg::*;
    typedef struct {logic p; logic w; logic [12:0] a; logic [31:0] d; logic [1:0] s; logic [31:0] e;} row_t;
    logic clk_i, rst_i, vcyc, vwe, dtack, pcyc, pstb, pwe, ack;
    logic [12:0] vadr, padr, fa;
    logic [31:0] vwd, vdat, pwd, pdat, q, r;
    logic [1:0] vsel, psel;
    int errors = 0, checks = 0, n, m;
    row_t rows[15] = '{'{1'h0,1'h1,13'h0105,32'h1234_5678,2'h3,32'h0}, '{1'h1,1'h0,13'h0105,32'h0,2'h3,32'h1234_5678},
        '{1'h1,1'h1,13'h0105,32'haaaa_bbbb,2'h1,32'h0}, '{1'h0,1'h0,13'h0105,32'h0,2'h3,32'h1234_bbbb},
        '{1'h1,1'h1,13'h07ff,32'h5555_0001,2'h3,32'h0}, '{1'h0,1'h0,13'h07ff,32'h0,2'h3,32'h5555_0001},
        '{1'h0,1'h0,13'h0900,32'h0,2'h3,32'h0}, '{1'h1,1'h0,13'h0900,32'h0,2'h3,32'h1},
        '{1'h1,1'h1,13'h0900,32'h1,2'h3,32'h0}, '{1'h0,1'h0,13'h0900,32'h0,2'h3,32'h1},
        '{1'h1,1'h1,13'h0900,32'h0,2'h3,32'h0}, '{1'h0,1'h0,13'h0900,32'h0,2'h3,32'h0},
        '{1'h0,1'h1,13'h1000,32'hcafe,2'h3,32'h0}, '{1'h1,1'h0,13'h1000,32'h0,2'h3,32'h0},
        '{1'h1,1'h0,13'h0f00,32'h0,2'h3,32'h0}};

    shared_buffer_semaphore_arbiter dut_u (.clk_i(clk_i), .rst_i(rst_i), .vme_cyc_i(vcyc), .vme_we_i(vwe),
        .vme_adr_i(vadr), .vme_dat_i(vwd), .vme_sel_i(vsel), .vme_dtack_o(dtack), .vme_dat_o(vdat),
        .pci_cyc_i(pcyc), .pci_stb_i(pstb), .pci_we_i(pwe), .pci_adr_i(padr), .pci_dat_i(pwd),
        .pci_sel_i(psel), .pci_ack_o(ack), .pci_dat_o(pdat));
    pci_host_model host_u (.clk_i(clk_i), .ack_i(ack), .rd_i(pdat), .cyc_o(pcyc), .stb_o(pstb),
        .we_o(pwe), .adr_o(padr), .wd_o(pwd), .sel_o(psel));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        end_of_test();
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Released address and data lines show inverted values, not the last ones; write and lane selects keep theirs
    task automatic vme(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [1:0] s,
        output logic [31:0] v, output int c);
        c = 0;
        @(posedge clk_i);
        {vcyc, vwe, vadr, vwd, vsel} <= {1'b1, w, a, d, s};
        do begin
            @(posedge clk_i);
            c++;
        end while (dtack !== 1'b1 && c < 200);
        if (c >= 200) errors++;
        v = vdat;
        vcyc <= 1'b0;
        vadr <= ~a;
        vwd <= ~d;
        @(posedge clk_i);
    endtask
    task automatic acc(input row_t x, output logic [31:0] v, output int c);
        if (x.p) host_u.xfer(x.w, x.a, x.d, x.s, 1'b0, v, c);
        else vme(x.w, x.a, x.d, x.s, v, c);
    endtask
    task automatic sys_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    initial begin
        {vcyc, vwe, vadr, vwd, vsel} = '0;
        rst_i = 1'b1;
        sys_reset();
        chk("idle_acks", {dtack, ack}, 32'h0);
        chk("idle_vdat", vdat, 32'h0);
        chk("idle_pdat", pdat, 32'h0);
        for (int i = 0; i < NUM_SEM; i++) begin
            fa = BUFFER_A_OWNERSHIP_FLAG_OFS + 13'(i * 256);
            host_u.xfer(1'b0, fa, 32'h0, 2'h3, 1'b0, q, n);
            chk("flag_free", q, 32'h0);
            chk("flag_wait", n, 32'h3);
            host_u.xfer(1'b0, fa, 32'h0, 2'h3, 1'b0, r, n);
            chk("flag_busy", r, 32'h1);
            vme(1'b1, fa, 32'h0, 2'h3, q, n);
        end
        foreach (rows[i]) begin
            acc(rows[i], q, n);
            if (!rows[i].w) chk("row", q, rows[i].e);
        end
        fork
            vme(1'b0, 13'h0a00, 32'h0, 2'h3, q, n);
            begin
                @(posedge clk_i);
                host_u.xfer(1'b0, 13'h0a00, 32'h0, 2'h3, 1'b0, r, m);
            end
        join
        chk("tie_vme", q, 32'h0);
        chk("tie_pci", r, 32'h1);
        host_u.xfer(1'b0, 13'h0300, 32'h0, 2'h3, 1'b1, r, m);
        vme(1'b0, 13'h0105, 32'h0, 2'h3, q, n);
        chk("other_buf", q, 32'h1234_bbbb);
        chk("other_wait", n, 32'h4);
        vme(1'b1, 13'h0300, 32'hdead_0001, 2'h3, q, n);
        chk("posted", n, 32'h2);
        fork
            vme(1'b0, 13'h1000, 32'h0, 2'h3, q, n);
            begin
                repeat (8) @(posedge clk_i);
                host_u.drop();
            end
        join
        chk("stalled", n > 8, 32'h1);
        chk("local", q, 32'hcafe);
        host_u.xfer(1'b0, 13'h0300, 32'h0, 2'h3, 1'b0, r, m);
        chk("delivered", r, 32'hdead_0001);
        vme(1'b0, BUFFER_A_OWNERSHIP_FLAG_OFS, 32'h0, 2'h3, q, n);
        sys_reset();
        host_u.xfer(1'b0, BUFFER_A_OWNERSHIP_FLAG_OFS, 32'h0, 2'h3, 1'b0, r, m);
        chk("reset_flag", r, 32'h0);
        end_of_test();
    end
endmodule // shared_buffer_semaphore_arbiter_test
`default_nettype wire
